// File: inc/aeacc_params.svh
// Summary of operation
// RULE_01: Sum active power into hidden 49-bit signed accumulator; expose upper 24 bits.
// RULE_02: One accumulation step every four master clock cycles.
// RULE_03: Samples are added with sign, so negative power lowers the energy.
// RULE_04: Positive-only mode lets only positive samples contribute.
// RULE_05: Divide by the 8-bit energy divider first; zero divides by one.
// RULE_06: Read-and-clear returns the energy value, then zeroes the upper 24 bits.
// RULE_07: Waveform shows power samples when mode 14:13 is zero and bit 3 set.
// RULE_08: Energy wraps positive to 0x800000 and negative to full-scale positive.
// RULE_09: Half-full and overflow/underflow conditions drive interrupt only when enabled.
// RULE_10: Add 16-bit signed offset trim; 256 counts equal one sample LSB.
// RULE_11: One internal pulse per LSB added to the energy value.
// RULE_12: One output pulse per (denominator+1)/(numerator+1) internal pulses.
// RULE_13: Numerator and denominator are unsigned 12-bit values.
// RULE_14: A zero numerator or denominator acts as one.
// RULE_15: A ratio above one is forced to one.
// RULE_16: Both settings one gives a fixed 16-tick pulse width.
// RULE_17: Pulse beyond 180 ms is fixed at 90 ms, else 50% duty.
// RULE_18: Mode bit 15 selects positive-only, off after reset; pulses follow it.
// RULE_19: Accumulation and pulse timers share one divide-by-four tick.
`ifndef AEACC_PARAMS_SVH
`define AEACC_PARAMS_SVH
`define AEACC_ACC_W 49
`define AEACC_TOP_W 24
`define AEACC_TOP_LSB 25
`define AEACC_TICK_LAST 2'h3
`define AEACC_TICK_DIV 4
`define AEACC_CLK_HZ 40000000
`define AEACC_LIMIT_MS 180
`define AEACC_HOLD_MS 90
`define AEACC_FIX_WIDTH 16
`define AEACC_WAVE_BASE 32
`define AEACC_MODE_POS_ONLY 15
`define AEACC_MODE_WSEL_HI 14
`define AEACC_MODE_WSEL_LO 13
`define AEACC_MODE_WRATE_HI 12
`define AEACC_MODE_WRATE_LO 11
`define AEACC_EN_HALF 0
`define AEACC_EN_OVF 1
`define AEACC_EN_WAVEFORM_SAMPLE_IRQ_ENABLE 3
`endif

// File: inc/aeacc_pkg.sv
package aeacc_pkg;
  typedef logic [23:0] aeacc_word_t;
  typedef enum logic [0:0] {PULSE_IDLE, PULSE_HIGH} aeacc_pulse_t;
endpackage

// File: core/aeacc_core.sv
`timescale 1ns/100ps
`include "aeacc_params.svh"

module aeacc_core #(
  parameter int PER_W = 22,
  parameter int LIMIT_TICKS =
    (`AEACC_CLK_HZ / (`AEACC_TICK_DIV * 1000)) * `AEACC_LIMIT_MS,
  parameter int HOLD_TICKS =
    (`AEACC_CLK_HZ / (`AEACC_TICK_DIV * 1000)) * `AEACC_HOLD_MS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Active power sample
  input wire logic [23:0] powerSample,
  // Settings
  input wire logic [15:0] modeReg,
  input wire logic [15:0] irqEnable,
  input wire logic [7:0] energyDivider,
  input wire logic [15:0] powerOffsetTrim,
  input wire logic [11:0] pulseRateNumerator,
  input wire logic [11:0] pulseRateDenominator,
  // Energy read
  input wire logic readClearStrobe,
  output aeacc_pkg::aeacc_word_t activeEnergyTotal,
  output aeacc_pkg::aeacc_word_t activeEnergyReadClear,
  // Waveform
  output aeacc_pkg::aeacc_word_t waveformSample,
  output logic waveformValid,
  // Events
  output logic halfFullEvent,
  output logic overflowEvent,
  output logic irqReq,
  // Calibration pulse
  output logic calibrationPulseOut
);

  function automatic logic [11:0] effSetting(input logic [11:0] v);
    effSetting = (v == 12'h000) ? 12'h001 : v;
  endfunction

  logic [1:0] divCnt_q;
  logic tick;
  logic signed [32:0] trimmed;
  logic [32:0] mag;
  logic [32:0] quot;
  logic [7:0] divEff;
  logic signed [48:0] contrib;
  logic signed [48:0] acc_q;
  logic signed [48:0] sum;
  logic signed [48:0] acc_d;
  logic [23:0] oldTop;
  logic [23:0] newTop;
  logic [23:0] deltaTop;
  logic [23:0] deltaMag;
  logic ovfNow;
  logic halfNow;
  logic halfPrev_q;
  logic [15:0] pending_q;
  logic dfcPulse;
  logic [11:0] numEff;
  logic [11:0] denEff;
  logic [11:0] numClamp;
  logic unityRatio;
  logic [13:0] frac_q;
  logic [13:0] fracSum;
  logic outEvent;
  logic [PER_W-1:0] period_q;
  logic [PER_W-1:0] width_q;
  logic [PER_W-1:0] widthNew;
  aeacc_pkg::aeacc_pulse_t pulseState_q;
  logic [8:0] waveCnt_q;
  logic [8:0] waveLimit;
  logic waveOn;

  // Divide-by-four tick
  always_ff @(posedge core_clk)
  begin
    if (srst)
      divCnt_q <= 2'h0;
    else
      divCnt_q <= divCnt_q + 2'h1;
  end

  assign tick = (divCnt_q == `AEACC_TICK_LAST); // RULE_02 RULE_19

  // Offset trim in 1/256 sample LSB
  assign trimmed = $signed({powerSample[23], powerSample, 8'h00})
    + $signed({{17{powerOffsetTrim[15]}}, powerOffsetTrim}); // RULE_10

  assign mag = trimmed[32] ? 33'(-trimmed) : trimmed;

  assign divEff = (energyDivider == 8'h00) ? 8'h01 : energyDivider; // RULE_05

  assign quot = mag / {25'h0000000, divEff}; // RULE_05

  // Signed contribution, gated in positive-only mode
  always_comb
  begin
    if (trimmed[32] && modeReg[`AEACC_MODE_POS_ONLY])
      contrib = '0; // RULE_04 RULE_18
    else if (trimmed[32])
      contrib = -$signed({16'h0000, quot}); // RULE_03
    else
      contrib = $signed({16'h0000, quot});
  end

  assign sum = acc_q + (tick ? contrib : 49'sh0); // RULE_01 RULE_08

  always_comb
  begin
    acc_d = sum;
    if (readClearStrobe)
      acc_d[48:`AEACC_TOP_LSB] = '0; // RULE_06
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      acc_q <= '0;
    else
      acc_q <= acc_d; // RULE_01
  end

  assign oldTop = acc_q[48:`AEACC_TOP_LSB];
  assign newTop = sum[48:`AEACC_TOP_LSB];
  assign activeEnergyTotal = oldTop; // RULE_01

  // Read-and-clear returns the value before clearing
  always_ff @(posedge core_clk)
  begin
    if (srst)
      activeEnergyReadClear <= '0;
    else if (readClearStrobe)
      activeEnergyReadClear <= oldTop; // RULE_06
  end

  // Wrap in either direction
  assign ovfNow = tick && (acc_q[48] == contrib[48])
    && (sum[48] != acc_q[48]); // RULE_08

  assign halfNow = acc_d[48] ^ acc_d[47];

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      halfPrev_q <= 1'b0;
      halfFullEvent <= 1'b0;
      overflowEvent <= 1'b0;
    end
    else
    begin
      halfPrev_q <= halfNow;
      halfFullEvent <= halfNow && !halfPrev_q; // RULE_09
      overflowEvent <= ovfNow; // RULE_09
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      irqReq <= 1'b0;
    else
      irqReq <= (halfNow && !halfPrev_q && irqEnable[`AEACC_EN_HALF])
        || (ovfNow && irqEnable[`AEACC_EN_OVF]); // RULE_09
  end

  // Internal pulses, one per energy LSB
  assign deltaTop = newTop - oldTop;
  assign deltaMag = deltaTop[23] ? 24'(-deltaTop) : deltaTop;
  assign dfcPulse = (pending_q != 16'h0000); // RULE_11

  always_ff @(posedge core_clk)
  begin
    if (srst)
      pending_q <= '0;
    else
      pending_q <= pending_q + deltaMag[15:0]
        - {15'h0000, dfcPulse}; // RULE_11 RULE_18
  end

  // Rate scaling
  assign numEff = effSetting(pulseRateNumerator); // RULE_13 RULE_14
  assign denEff = effSetting(pulseRateDenominator); // RULE_13 RULE_14
  assign numClamp = (numEff > denEff) ? denEff : numEff; // RULE_15
  assign unityRatio = (numEff == 12'h001) && (denEff == 12'h001);

  assign fracSum = frac_q + (dfcPulse ? {1'b0, numClamp} + 14'h0001 : 14'h0000);
  assign outEvent = (fracSum >= {1'b0, denEff} + 14'h0001); // RULE_12

  always_ff @(posedge core_clk)
  begin
    if (srst)
      frac_q <= '0;
    else if (outEvent)
      frac_q <= fracSum - {1'b0, denEff} - 14'h0001; // RULE_12
    else
      frac_q <= fracSum;
  end

  // Ticks since the previous output pulse
  always_ff @(posedge core_clk)
  begin
    if (srst)
      period_q <= '0;
    else if (outEvent)
      period_q <= '0;
    else if (tick && (period_q <= PER_W'(LIMIT_TICKS)))
      period_q <= period_q + 1'b1; // RULE_19
  end

  // Pulse width selection
  always_comb
  begin
    if (unityRatio)
      widthNew = PER_W'(`AEACC_FIX_WIDTH); // RULE_16
    else if (period_q > PER_W'(LIMIT_TICKS))
      widthNew = PER_W'(HOLD_TICKS); // RULE_17
    else if (period_q < PER_W'(2))
      widthNew = PER_W'(1);
    else
      widthNew = period_q >> 1; // RULE_17
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pulseState_q <= aeacc_pkg::PULSE_IDLE;
      width_q <= '0;
    end
    else
    begin
      case (pulseState_q)
        aeacc_pkg::PULSE_IDLE:
        begin
          if (outEvent)
          begin
            pulseState_q <= aeacc_pkg::PULSE_HIGH;
            width_q <= widthNew;
          end
        end
        aeacc_pkg::PULSE_HIGH:
        begin
          if (outEvent)
            width_q <= widthNew;
          else if (tick && (width_q == PER_W'(1)))
          begin
            pulseState_q <= aeacc_pkg::PULSE_IDLE;
            width_q <= '0;
          end
          else if (tick)
            width_q <= width_q - 1'b1; // RULE_19
        end
        default:
        begin
          pulseState_q <= aeacc_pkg::PULSE_IDLE;
          width_q <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      calibrationPulseOut <= 1'b0;
    else
      calibrationPulseOut <= (pulseState_q == aeacc_pkg::PULSE_HIGH);
  end

  // Waveform sampling
  assign waveLimit = 9'(`AEACC_WAVE_BASE)
    << modeReg[`AEACC_MODE_WRATE_HI:`AEACC_MODE_WRATE_LO];

  assign waveOn = (modeReg[`AEACC_MODE_WSEL_HI:`AEACC_MODE_WSEL_LO] == 2'h0)
    && irqEnable[`AEACC_EN_WAVEFORM_SAMPLE_IRQ_ENABLE]; // RULE_07

  always_ff @(posedge core_clk)
  begin
    if (srst)
      waveCnt_q <= '0;
    else if (tick && (waveCnt_q >= waveLimit - 9'h001))
      waveCnt_q <= '0;
    else if (tick)
      waveCnt_q <= waveCnt_q + 9'h001;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      waveformSample <= '0;
      waveformValid <= 1'b0;
    end
    else
    begin
      waveformValid <= 1'b0;
      if (waveOn && tick && (waveCnt_q >= waveLimit - 9'h001))
      begin
        waveformSample <= trimmed[31:8]; // RULE_07
        waveformValid <= 1'b1;
      end
    end
  end

  a_tick_spacing: assert property (@(posedge core_clk) disable iff (srst)
    tick |=> !tick [*3] ##1 tick) // RULE_02
    else $error("Tick spacing wrong");

  a_acc_hold: assert property (@(posedge core_clk) disable iff (srst)
    !tick && !readClearStrobe |=> acc_q == $past(acc_q)) // RULE_02
    else $error("Accumulator moved off tick");

  a_signed_add: assert property (@(posedge core_clk) disable iff (srst)
    tick && !readClearStrobe |=> acc_q == $past(acc_q) + $past(contrib)) // RULE_03
    else $error("Signed step wrong");

  a_pos_only: assert property (@(posedge core_clk) disable iff (srst)
    modeReg[`AEACC_MODE_POS_ONLY] |-> !contrib[48]) // RULE_04
    else $error("Negative step in positive-only mode");

  a_div_zero: assert property (@(posedge core_clk) disable iff (srst)
    energyDivider == 8'h00 && !trimmed[32] |-> contrib == $signed({16'h0000, mag})) // RULE_05
    else $error("Zero divider not unity");

  a_read_clear: assert property (@(posedge core_clk) disable iff (srst)
    readClearStrobe |=> activeEnergyReadClear == $past(oldTop)
    && activeEnergyTotal == 24'h000000) // RULE_06
    else $error("Read-and-clear wrong");

  a_ovf_irq: assert property (@(posedge core_clk) disable iff (srst)
    ovfNow && irqEnable[`AEACC_EN_OVF] |=> irqReq && overflowEvent) // RULE_09
    else $error("Overflow not signalled");

  a_ratio_clamp: assert property (@(posedge core_clk) disable iff (srst)
    numClamp <= denEff && numClamp != 12'h000) // RULE_15
    else $error("Ratio above one");

  a_unity_width: assert property (@(posedge core_clk) disable iff (srst)
    outEvent && unityRatio |=> width_q == PER_W'(`AEACC_FIX_WIDTH)) // RULE_16
    else $error("Unity pulse width wrong");

  a_long_width: assert property (@(posedge core_clk) disable iff (srst)
    outEvent && !unityRatio && period_q > PER_W'(LIMIT_TICKS)
    |=> width_q == PER_W'(HOLD_TICKS)) // RULE_17
    else $error("Long pulse not held");

endmodule // aeacc_core

// File: bench/aeacc_cal_counter.sv
`timescale 1ns/100ps

module aeacc_cal_counter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Pulse from the meter
  input wire logic calibrationPulseOut,
  // Measurements
  output logic [15:0] pulseCount,
  output logic [15:0] lastWidth
);
  logic [15:0] highCnt_q;
  logic prev_q;

  // Counts rising edges and the width of the last pulse in clocks
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pulseCount <= 16'h0000;
      lastWidth <= 16'h0000;
      highCnt_q <= 16'h0000;
      prev_q <= 1'b0;
    end
    else
    begin
      prev_q <= calibrationPulseOut;
      if (calibrationPulseOut && !prev_q)
        pulseCount <= pulseCount + 16'h0001;
      if (calibrationPulseOut)
        highCnt_q <= highCnt_q + 16'h0001;
      else if (prev_q)
      begin
        lastWidth <= highCnt_q;
        highCnt_q <= 16'h0000;
      end
    end
  end
endmodule // aeacc_cal_counter

// File: bench/active_energy_accumulator_pulse_out_bench.sv
`timescale 1ns/100ps
`define AEACC_CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin nMismatch++; $display("Error %s expected %h seen %h", nm, ex, got); end end

module active_energy_accumulator_pulse_out_bench;
  logic core_clk;
  logic srst;
  logic [23:0] powerSample;
  logic [15:0] modeReg;
  logic [15:0] irqEnable;
  logic [7:0] energyDivider;
  logic [15:0] powerOffsetTrim;
  logic [11:0] pulseRateNumerator;
  logic [11:0] pulseRateDenominator;
  logic readClearStrobe;
  aeacc_pkg::aeacc_word_t activeEnergyTotal;
  aeacc_pkg::aeacc_word_t activeEnergyReadClear;
  aeacc_pkg::aeacc_word_t waveformSample;
  aeacc_pkg::aeacc_word_t wsSeen;
  logic [23:0] prevPower;
  logic waveformValid;
  logic calibrationPulseOut;
  logic [15:0] pulseCount;
  logic [15:0] lastWidth;
  int nMismatch;
  int samplesChecked;

  aeacc_core #(.LIMIT_TICKS(200), .HOLD_TICKS(100)) aeacc_core_inst (
    .core_clk(core_clk), .srst(srst), .powerSample(powerSample), .modeReg(modeReg),
    .irqEnable(irqEnable), .energyDivider(energyDivider), .powerOffsetTrim(powerOffsetTrim),
    .pulseRateNumerator(pulseRateNumerator), .pulseRateDenominator(pulseRateDenominator),
    .readClearStrobe(readClearStrobe), .activeEnergyTotal(activeEnergyTotal),
    .activeEnergyReadClear(activeEnergyReadClear), .waveformSample(waveformSample),
    .waveformValid(waveformValid), .halfFullEvent(), .overflowEvent(), .irqReq(),
    .calibrationPulseOut(calibrationPulseOut));

  aeacc_cal_counter aeacc_cal_counter_inst (
    .core_clk(core_clk), .srst(srst), .calibrationPulseOut(calibrationPulseOut),
    .pulseCount(pulseCount), .lastWidth(lastWidth));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Keep only samples taken while trimmed power was applied
  always @(posedge core_clk)
  begin
    prevPower <= powerSample;
    if (srst)
      wsSeen <= 24'h000000;
    else if (waveformValid && prevPower == 24'h01ffff)
      wsSeen <= waveformSample;
  end

  task automatic finish_test();
    if (nMismatch == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Whole number of ticks with power applied, then settle
  task automatic run(input logic [23:0] p, input int n);
    powerSample = p;
    repeat (4 * n) @(negedge core_clk);
    powerSample = 24'h000000;
    repeat (8) @(negedge core_clk);
  endtask

  task automatic cal(input logic [11:0] num, input logic [11:0] den, input int n, input int k,
    input int gap, input logic [15:0] expW);
    logic [15:0] base;
    pulseRateNumerator = num;
    pulseRateDenominator = den;
    repeat (1000) @(negedge core_clk);
    base = pulseCount;
    repeat (k)
    begin
      run(24'h020000, n);
      repeat (gap) @(negedge core_clk);
    end
    `AEACC_CHK("pulse count", k[15:0], pulseCount - base)
    if (expW != 16'h0000)
      `AEACC_CHK("pulse width", 1'b1, (lastWidth + 16'h0005 >= expW) && (lastWidth <= expW + 16'h0005))
  endtask

  initial
  begin
    nMismatch = 0;
    samplesChecked = 0;
    srst = 1'b1;
    powerSample = 24'h000000;
    modeReg = 16'h0000;
    irqEnable = 16'h0000;
    energyDivider = 8'h00;
    powerOffsetTrim = 16'h0000;
    pulseRateNumerator = 12'h000;
    pulseRateDenominator = 12'h000;
    readClearStrobe = 1'b0;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    `AEACC_CHK("total after reset", 24'h000000, activeEnergyTotal)
    run(24'h020000, 5);
    `AEACC_CHK("total up", 24'h000005, activeEnergyTotal)
    run(24'hfe0000, 2);
    `AEACC_CHK("total down", 24'h000003, activeEnergyTotal)
    energyDivider = 8'h02;
    run(24'h040000, 3);
    `AEACC_CHK("total divided", 24'h000006, activeEnergyTotal)
    energyDivider = 8'h00;
    readClearStrobe = 1'b1;
    @(negedge core_clk);
    readClearStrobe = 1'b0;
    @(negedge core_clk);
    `AEACC_CHK("read clear value", 24'h000006, activeEnergyReadClear)
    `AEACC_CHK("total cleared", 24'h000000, activeEnergyTotal)
    modeReg = 16'h8000;
    run(24'hfe0000, 3);
    `AEACC_CHK("negative ignored", 24'h000000, activeEnergyTotal)
    run(24'h020000, 2);
    `AEACC_CHK("positive kept", 24'h000002, activeEnergyTotal)
    modeReg = 16'h0000;
    powerOffsetTrim = 16'h0100;
    irqEnable = 16'h0008;
    run(24'h01ffff, 40);
    powerOffsetTrim = 16'h0000;
    irqEnable = 16'h0000;
    `AEACC_CHK("trimmed total", 24'h00002a, activeEnergyTotal)
    `AEACC_CHK("waveform sample", 24'h020000, wsSeen)
    cal(12'h000, 12'h000, 1, 3, 1000, 16'h0040);
    cal(12'h000, 12'h005, 3, 2, 1000, 16'h0190);
    cal(12'h005, 12'h002, 1, 2, 1000, 16'h0190);
    cal(12'h005, 12'h002, 1, 3, 588, 16'h012c);
    finish_test();
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    nMismatch++;
    finish_test();
  end
endmodule // active_energy_accumulator_pulse_out_bench
